/* ttem_defines.svh */
// Purpose: constants for the timer channel
// Assumes: 32-bit register port, word-aligned byte offsets
// Notes:   offsets are byte addresses
`ifndef TTEM_DEFINES_SVH
`define TTEM_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define TTEM_OFS_CSR     8'h00
`define TTEM_OFS_LOAD    8'h04
`define TTEM_OFS_CMP     8'h08
`define TTEM_OFS_COUNT   8'h0C

// ****************************************
// control/status field positions
// ****************************************
`define TTEM_CSR_RUN     0
`define TTEM_CSR_CIE     2
`define TTEM_CSR_OIE     1
`define TTEM_CSR_MODE_LO 4
`define TTEM_CSR_MODE_HI 7
`define TTEM_CSR_INV     8
`define TTEM_CSR_RELOAD  9
`define TTEM_CSR_PRESC   15
`define TTEM_CSR_OVF     20
`define TTEM_CSR_CMPF    21

// ****************************************
// reset values
// ****************************************
`define TTEM_RST_24      24'h00_0000
`define TTEM_RST_MODE    4'h0

`endif

/* ttem_pkg.sv */
// Purpose: types for the timer channel
// Assumes: ttem_defines.svh holds the numbers
// Notes:   none
package ttem_pkg;

  typedef enum logic [3:0] {
    TTEM_MODE_TOGGLE = 4'b0010,
    TTEM_MODE_EVENT  = 4'b0011,
    TTEM_MODE_WIDTH  = 4'b0100,
    TTEM_MODE_PERIOD = 4'b0101,
    TTEM_MODE_CAPT   = 4'b0110
  } ttem_mode_t;

  typedef enum logic [1:0] {
    TTEM_ST_IDLE  = 2'b00,
    TTEM_ST_WAIT  = 2'b01,
    TTEM_ST_LOAD  = 2'b10,
    TTEM_ST_COUNT = 2'b11
  } ttem_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ttem_bus_req_t;

  typedef struct packed {
    logic       run;
    logic [3:0] mode;
    logic       polarity_select_bit;
    logic       reload;
    logic       presc;
    logic       cie;
    logic       oie;
  } ttem_ctrl_t;

endpackage : ttem_pkg

/* ttem_timer.sv */
// Purpose: one 24-bit timer channel, toggle, event and measurement modes
// Assumes: timer_pin_in synchronous-free async source, synchronised here
// Notes:   flags clear by writing one; a set in the same cycle wins
//
// How it works
// R1 - mode field picks toggle, event, width, period, capture
// R2 - enable clears counter, load value on first tick
// R3 - timer tick from clock/2 or prescaler
// R4 - toggle: pin starts at polarity, inverts on match
// R5 - match then reload if reload bit set
// R6 - overflow sets flag, interrupt if enabled
// R7 - count register readable without disturbing counting
// R8 - software sets load to X/2 for toggles
// R9 - event ticks from pin or prescaler, source slow
// R10 - event edge chosen by polarity bit
// R11 - event match sets compare flag, interrupt
// R12 - pin synchronised, result within one tick
// R13 - width starts on chosen edge, loads next tick
// R14 - width opposite edge stops, flags, captures count; without the reload bit the code stays in COUNT and keeps counting
// R15 - width reload on tick after next start edge
// R16 - period chosen edge starts count from load value
// R17 - period next same edge flags and captures
// R18 - period reload restarts from load value
// R19 - capture counts from enable, halts on edge
// R20 - capture edge chosen by polarity bit
// R21 - software changes mode only while disabled
// R22 - two-stage pin synchroniser then edge compare
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "ttem_defines.svh"

module ttem_timer (
  input  wire logic               mclk,
  input  wire logic               rstn,
  input  wire ttem_pkg::ttem_bus_req_t bus_req,
  output logic [31:0]             rdata,
  input  wire logic               presc_tick,
  input  wire logic               timer_pin_in,
  output logic                    timer_pin_out,
  output logic                    timer_pin_oe_n,
  output logic                    compare_irq,
  output logic                    overflow_irq
);
  import ttem_pkg::*;

  // ****************************************
  // registers and state
  // ****************************************
  ttem_ctrl_t  ctrl_q;
  logic [23:0] load_value_reg_q;
  logic [23:0] compare_value_reg_q;
  logic [23:0] count_capture_reg_q;
  logic [23:0] cnt_q;
  logic        compare_flag_q;
  logic        overflow_flag_q;
  logic        pin_q;
  logic        div_q;
  logic        sync1_q;
  logic        sync2_q;
  logic        prev_q;
  logic [31:0] rdata_q;
  logic        run_d1_q;
  ttem_state_t st_q;

  logic        wr_csr;
  logic        tick;
  logic        rise;
  logic        fall;
  logic        start_edge;
  logic        stop_edge;
  logic        match;
  logic        ovf;
  logic        run_rise;
  logic        inc_en;
  logic [24:0] cnt_inc;
  logic        meas_stop;
  logic        cmp_set;

  function automatic logic sel_edge(input logic polarity_select_bit, input logic r, input logic f);
    sel_edge = polarity_select_bit ? f : r;
  endfunction : sel_edge

  assign wr_csr = bus_req.wr && (bus_req.addr == `TTEM_OFS_CSR);

  // ****************************************
  // pin synchroniser and edges
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= timer_pin_in; // R22
      sync2_q <= sync1_q;      // R12
      prev_q  <= sync2_q;      // R22
    end
  end

  assign rise = sync2_q & ~prev_q; // R22
  assign fall = ~sync2_q & prev_q; // R22
  assign start_edge = sel_edge(ctrl_q.polarity_select_bit, rise, fall); // R13 R16 R20
  assign stop_edge  = sel_edge(ctrl_q.polarity_select_bit, fall, rise); // R14

  // ****************************************
  // timer tick source
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      div_q <= 1'b0;
    end else begin
      div_q <= ctrl_q.run ? ~div_q : 1'b0;
    end
  end

  always_comb begin
    if (ctrl_q.mode == TTEM_MODE_EVENT && !ctrl_q.presc) begin
      tick = start_edge; // R9 R10
    end else if (ctrl_q.presc) begin
      tick = presc_tick; // R3 R9
    end else begin
      tick = div_q;      // R3
    end
  end

  // ****************************************
  // counter sequencing
  // ****************************************
  assign run_rise  = ctrl_q.run & ~run_d1_q;
  assign cnt_inc   = {1'b0, cnt_q} + 25'h000_0001;
  assign match     = inc_en && (cnt_q == compare_value_reg_q) &&
                     (ctrl_q.mode == TTEM_MODE_TOGGLE || ctrl_q.mode == TTEM_MODE_EVENT);
  assign inc_en    = ctrl_q.run && (st_q == TTEM_ST_COUNT) && tick;
  assign ovf       = inc_en && cnt_inc[24]; // R6
  assign meas_stop = (st_q == TTEM_ST_COUNT) && ctrl_q.run &&
                     (((ctrl_q.mode == TTEM_MODE_WIDTH) && stop_edge) ||
                      ((ctrl_q.mode == TTEM_MODE_PERIOD) && start_edge) ||
                      ((ctrl_q.mode == TTEM_MODE_CAPT) && start_edge));
  assign cmp_set   = match || meas_stop;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      run_d1_q <= 1'b0;
    end else begin
      run_d1_q <= ctrl_q.run;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_q  <= TTEM_ST_IDLE;
      cnt_q <= `TTEM_RST_24;
    end else if (!ctrl_q.run) begin
      st_q <= TTEM_ST_IDLE;
    end else if (run_rise) begin
      cnt_q <= `TTEM_RST_24; // R2
      if (ctrl_q.mode == TTEM_MODE_WIDTH || ctrl_q.mode == TTEM_MODE_PERIOD) begin
        st_q <= TTEM_ST_WAIT; // R13 R16
      end else begin
        st_q <= TTEM_ST_LOAD; // R2 R19
      end
    end else begin
      unique case (st_q)
        TTEM_ST_IDLE: begin
          st_q <= TTEM_ST_IDLE;
        end
        TTEM_ST_WAIT: begin
          if (start_edge) begin
            st_q <= TTEM_ST_LOAD; // R13 R15 R16
          end
        end
        TTEM_ST_LOAD: begin
          if (tick) begin
            cnt_q <= load_value_reg_q; // R2 R13 R16 R19
            st_q  <= TTEM_ST_COUNT;
          end
        end
        TTEM_ST_COUNT: begin
          if (meas_stop) begin
            unique case (ctrl_q.mode)
              TTEM_MODE_WIDTH: begin
                st_q <= ctrl_q.reload ? TTEM_ST_WAIT : TTEM_ST_COUNT; // R14 R15
              end
              TTEM_MODE_PERIOD: begin
                if (ctrl_q.reload) begin
                  st_q <= TTEM_ST_LOAD; // R18
                end else if (tick) begin
                  cnt_q <= cnt_inc[23:0]; // R18
                end
              end
              default: begin
                st_q <= TTEM_ST_IDLE; // R19
              end
            endcase
          end else if (match && ctrl_q.reload) begin
            st_q <= TTEM_ST_LOAD; // R5
          end else if (inc_en) begin
            cnt_q <= cnt_inc[23:0]; // R2 R5
          end
        end
      endcase
    end
  end

  // ****************************************
  // timer pin drive
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pin_q <= 1'b0;
    end else if (run_rise) begin
      pin_q <= ctrl_q.polarity_select_bit; // R4
    end else if (match && ctrl_q.mode == TTEM_MODE_TOGGLE) begin
      pin_q <= ~pin_q; // R4
    end
  end

  assign timer_pin_out  = pin_q;
  assign timer_pin_oe_n = ~(ctrl_q.mode == TTEM_MODE_TOGGLE); // R1

  // ****************************************
  // flags
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      compare_flag_q <= 1'b0;
    end else if (cmp_set) begin
      compare_flag_q <= 1'b1; // R4 R11 R14 R17 R19
    end else if (!ctrl_q.run) begin
      compare_flag_q <= 1'b0;
    end else if (wr_csr && bus_req.wdata[`TTEM_CSR_CMPF]) begin
      compare_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      overflow_flag_q <= 1'b0;
    end else if (ovf) begin
      overflow_flag_q <= 1'b1; // R6
    end else if (wr_csr && bus_req.wdata[`TTEM_CSR_OVF]) begin
      overflow_flag_q <= 1'b0;
    end
  end

  assign compare_irq  = compare_flag_q & ctrl_q.cie;   // R4 R11
  assign overflow_irq = overflow_flag_q & ctrl_q.oie;  // R6

  // ****************************************
  // capture register
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      count_capture_reg_q <= `TTEM_RST_24;
    end else if (meas_stop) begin
      count_capture_reg_q <= cnt_q; // R14 R17 R19
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrl_q              <= '0;
      load_value_reg_q    <= `TTEM_RST_24;
      compare_value_reg_q <= `TTEM_RST_24;
    end else if (bus_req.wr) begin
      unique case (bus_req.addr)
        `TTEM_OFS_CSR: begin
          ctrl_q.run    <= bus_req.wdata[`TTEM_CSR_RUN];
          ctrl_q.mode   <= bus_req.wdata[`TTEM_CSR_MODE_HI:`TTEM_CSR_MODE_LO]; // R1 R21
          ctrl_q.polarity_select_bit    <= bus_req.wdata[`TTEM_CSR_INV];
          ctrl_q.reload <= bus_req.wdata[`TTEM_CSR_RELOAD];
          ctrl_q.presc  <= bus_req.wdata[`TTEM_CSR_PRESC];
          ctrl_q.cie    <= bus_req.wdata[`TTEM_CSR_CIE];
          ctrl_q.oie    <= bus_req.wdata[`TTEM_CSR_OIE];
        end
        `TTEM_OFS_LOAD: begin
          load_value_reg_q <= bus_req.wdata[23:0]; // R8
        end
        `TTEM_OFS_CMP: begin
          compare_value_reg_q <= bus_req.wdata[23:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        `TTEM_OFS_CSR: begin
          rdata_q <= 32'h0000_0000;
          rdata_q[`TTEM_CSR_RUN]    <= ctrl_q.run;
          rdata_q[`TTEM_CSR_OIE]    <= ctrl_q.oie;
          rdata_q[`TTEM_CSR_CIE]    <= ctrl_q.cie;
          rdata_q[`TTEM_CSR_MODE_HI:`TTEM_CSR_MODE_LO] <= ctrl_q.mode;
          rdata_q[`TTEM_CSR_INV]    <= ctrl_q.polarity_select_bit;
          rdata_q[`TTEM_CSR_RELOAD] <= ctrl_q.reload;
          rdata_q[`TTEM_CSR_PRESC]  <= ctrl_q.presc;
          rdata_q[`TTEM_CSR_OVF]    <= overflow_flag_q;
          rdata_q[`TTEM_CSR_CMPF]   <= compare_flag_q;
        end
        `TTEM_OFS_LOAD: begin
          rdata_q <= 32'h0000_0000;
        end
        `TTEM_OFS_CMP: begin
          rdata_q <= {8'h00, compare_value_reg_q};
        end
        `TTEM_OFS_COUNT: begin
          if (ctrl_q.mode == TTEM_MODE_TOGGLE || ctrl_q.mode == TTEM_MODE_EVENT) begin
            rdata_q <= {8'h00, cnt_q}; // R7
          end else begin
            rdata_q <= {8'h00, count_capture_reg_q}; // R7
          end
        end
        default: begin
          rdata_q <= 32'h0000_0000;
        end
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign rdata = rdata_q;

endmodule : ttem_timer
`default_nettype wire

/* ttem_timer_asserts.sv */
// Purpose: port checker for ttem_timer
// Assumes: bus master keeps the one-cycle strobe contract
// Notes:   shadows control and compare writes seen on bus_req
`timescale 1ns/1ps
`default_nettype none
`include "ttem_defines.svh"

module ttem_timer_chk (
  input wire logic                    mclk,
  input wire logic                    rstn,
  input wire ttem_pkg::ttem_bus_req_t bus_req,
  input wire logic [31:0]             rdata,
  input wire logic                    timer_pin_out,
  input wire logic                    timer_pin_oe_n,
  input wire logic                    compare_irq,
  input wire logic                    overflow_irq
);
  import ttem_pkg::*;
  logic [15:0] csr_q;
  logic [23:0] cmp_q;
  logic        wcsr;

  assign wcsr = bus_req.wr && bus_req.addr == `TTEM_OFS_CSR;

  always_ff @(posedge mclk) begin
    if (!rstn) csr_q <= 16'h0000;
    else if (wcsr) csr_q <= bus_req.wdata[15:0];
  end

  always_ff @(posedge mclk) begin
    if (!rstn) cmp_q <= 24'h00_0000;
    else if (bus_req.wr && bus_req.addr == `TTEM_OFS_CMP) cmp_q <= bus_req.wdata[23:0];
  end

  // ****
  // properties
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_pin_dir: assert property (wcsr |=> timer_pin_oe_n == (csr_q[7:4] != 4'h2))
    else $error("pin direction does not follow mode");
  a_pin_start: assert property (wcsr && bus_req.wdata[0] && !csr_q[0] &&
    bus_req.wdata[7:4] == 4'h2 |=> ##1 timer_pin_out == csr_q[8])
    else $error("toggle pin did not start at polarity");
  a_read_idle: assert property (!bus_req.rd |=> rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
  a_read_refuse: assert property (bus_req.rd && (bus_req.addr == `TTEM_OFS_LOAD ||
    bus_req.addr > `TTEM_OFS_COUNT || bus_req.addr[1:0] != 2'b00) |=> rdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_cmp_back: assert property (bus_req.rd && bus_req.addr == `TTEM_OFS_CMP |=>
    rdata == {8'h00, cmp_q})
    else $error("compare readback wrong");
  a_ctrl_back: assert property (bus_req.rd && bus_req.addr == `TTEM_OFS_CSR |=>
    (rdata[15:0] & 16'h83f7) == (csr_q & 16'h83f7))
    else $error("control readback wrong");
  a_cirq_en: assert property (compare_irq |-> csr_q[2])
    else $error("compare irq while disabled");
  a_oirq_en: assert property (overflow_irq |-> csr_q[1])
    else $error("overflow irq while disabled");
  a_stop_clear: assert property (wcsr && !bus_req.wdata[0] |-> ##2 !compare_irq)
    else $error("compare flag kept after stop");

  c_toggle: cover property (!timer_pin_oe_n && $changed(timer_pin_out));
  c_cmp: cover property ($rose(compare_irq));
  c_ovf: cover property ($rose(overflow_irq));
endmodule : ttem_timer_chk

bind ttem_timer ttem_timer_chk u_chk (
  .mclk(mclk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
  .timer_pin_out(timer_pin_out), .timer_pin_oe_n(timer_pin_oe_n),
  .compare_irq(compare_irq), .overflow_irq(overflow_irq)
);
`default_nettype wire

/* ttem_pin_src.sv */
// Purpose: far-side source and load on the timer pin
// Assumes: bench commands levels through set_level
// Notes:   source yields the wire while the block drives it
`timescale 1ns/1ps
`default_nettype none

module ttem_pin_src (
  input  wire logic mclk,
  input  wire logic timer_pin_out,
  input  wire logic timer_pin_oe_n,
  output logic      pin_level
);
  logic ext_q = 1'b0;

  assign pin_level = timer_pin_oe_n ? ext_q : timer_pin_out;

  // new level after gap edges, assigned nonblocking on the last of those edges
  task automatic set_level(input logic v, input int gap);
    repeat (gap) @(posedge mclk);
    ext_q <= v;
  endtask : set_level
endmodule : ttem_pin_src
`default_nettype wire

/* testbench.sv */
// Purpose: self-checking bench for ttem_timer
// Assumes: clock/2 ticks unless prescaler selected; event mode without prescaler ticks on pin edges
// Notes:   measured counts allow for pin synchronisation
`timescale 1ns/1ps
`default_nettype none
`include "ttem_defines.svh"

module testbench;
  import ttem_pkg::*;
  logic          mclk, rstn, pin_level, pin_out, oe_n, cirq, oirq;
  logic          presc_tick = 1'b0;
  ttem_bus_req_t bus_req;
  logic [31:0]   rdata, d;
  int            n_mismatch, checked, t0, k, ld, n;

  ttem_timer dut (.mclk(mclk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
    .presc_tick(presc_tick), .timer_pin_in(pin_level), .timer_pin_out(pin_out),
    .timer_pin_oe_n(oe_n), .compare_irq(cirq), .overflow_irq(oirq));
  ttem_pin_src src (.mclk(mclk), .timer_pin_out(pin_out), .timer_pin_oe_n(oe_n),
    .pin_level(pin_level));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) presc_tick <= 1'($urandom_range(0, 1));

  // ****
  // tasks
  // ****
  task automatic wrap_up;
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("FAIL %s exp %h got %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk

  task automatic chk_near(input string nm, input int e, input logic [31:0] g);
    checked++;
    if ($isunknown(g) || g > e + 2 || g + 2 < e) begin
      $display("FAIL %s exp %0d got %0d", nm, e, g);
      n_mismatch++;
    end
  endtask : chk_near

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk) bus_req <= {a, v, 2'b10};
    @(posedge mclk) bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk) bus_req <= {a, 32'h0000_0000, 2'b01};
    @(posedge mclk) bus_req.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd

  task automatic wait_pin(output int c);
    logic p;
    p = pin_out;
    for (c = 1; c < 200; c++) begin
      @(posedge mclk);
      #1;
      if (pin_out !== p) return;
    end
    n_mismatch++;
    wrap_up();
  endtask : wait_pin

  task automatic meas(input logic [3:0] m, input logic polarity_select_bit, input int w);
    wr(`TTEM_OFS_CSR, 32'h0000_0000);
    src.set_level(polarity_select_bit, 4);
    wr(`TTEM_OFS_LOAD, 32'h0000_0000);
    wr(`TTEM_OFS_CSR, {22'h0, 1'b1, polarity_select_bit, m, 4'h5});
    if (m == TTEM_MODE_CAPT) src.set_level(!polarity_select_bit, w);
    else begin
      src.set_level(!polarity_select_bit, 4);
      repeat (2) begin
        if (m == TTEM_MODE_WIDTH) begin
          src.set_level(polarity_select_bit, w);
          src.set_level(!polarity_select_bit, 4);
        end else begin
          src.set_level(polarity_select_bit, w / 2);
          src.set_level(!polarity_select_bit, w - w / 2);
        end
      end
    end
    repeat (8) @(posedge mclk);
    rd(`TTEM_OFS_COUNT, d);
    chk_near("measured", w / 2, d);
    chk("meas irq", 1, cirq);
  endtask : meas

  // ****
  // sequence
  // ****
  initial begin
    d = $urandom(32'h0000_9cb7);
    bus_req = '0;
    rstn = 1'b0;
    n_mismatch = 0;
    checked = 0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    rd(`TTEM_OFS_CSR, d);
    chk("csr reset", 0, d);
    chk("dir reset", 1, oe_n);
    k = $urandom_range(0, 32'h00ff_ffff);
    wr(`TTEM_OFS_CMP, k);
    rd(`TTEM_OFS_CMP, d);
    chk("cmp back", k, d);
    rd(`TTEM_OFS_LOAD, d);
    chk("load read", 0, d);
    rd(8'h10, d);
    chk("unmapped", 0, d);
    ld = $urandom_range(0, 3);
    k = $urandom_range(1, 4);
    n = $urandom_range(0, 1);
    wr(`TTEM_OFS_LOAD, ld);
    wr(`TTEM_OFS_CMP, ld + k);
    wr(`TTEM_OFS_CSR, 32'h0000_0225 | (n << 8));
    @(posedge mclk);
    #1;
    chk("pin start", n, pin_out);
    chk("pin dir", 0, oe_n);
    wait_pin(t0);
    wait_pin(t0);
    chk("toggle gap", 2 * (k + 2), t0);
    chk("cmp irq", 1, cirq);
    for (int polarity_select_bit = 0; polarity_select_bit < 2; polarity_select_bit++) begin
      wr(`TTEM_OFS_CSR, 32'h0000_0000);
      src.set_level(polarity_select_bit[0], 4);
      ld = $urandom_range(0, 100);
      n = $urandom_range(2, 6);
      wr(`TTEM_OFS_LOAD, ld);
      wr(`TTEM_OFS_CMP, ld + n - 2);
      wr(`TTEM_OFS_CSR, 32'h0000_0035 | (polarity_select_bit << 8));
      repeat (n) begin
        src.set_level(!polarity_select_bit[0], $urandom_range(4, 9));
        src.set_level(polarity_select_bit[0], $urandom_range(4, 9));
      end
      repeat (6) @(posedge mclk);
      rd(`TTEM_OFS_COUNT, d);
      chk("event count", ld + n - 1, d);
      chk("event irq", 1, cirq);
    end
    for (int m = 4; m < 7; m++) meas(m[3:0], 1'($urandom_range(0, 1)), $urandom_range(20, 60));
    wr(`TTEM_OFS_CSR, 32'h0000_0000);
    wr(`TTEM_OFS_LOAD, 32'h00ff_fff0);
    wr(`TTEM_OFS_CMP, 32'h0000_0000);
    wr(`TTEM_OFS_CSR, 32'h0000_8023);
    repeat (120) @(posedge mclk);
    chk("ovf irq", 1, oirq);
    rd(`TTEM_OFS_CSR, d);
    chk("ovf flag", 1, d[20]);
    wr(`TTEM_OFS_CSR, 32'h0010_0000);
    rd(`TTEM_OFS_CSR, d);
    chk("ovf clear", 0, d[20]);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
